// File: mceq_params.svh
// Constants of the multichannel event queue: offsets, field positions, reset values
//
// Summary of operation
// - Queue entry is 16 bits: valid bit 0, wrap bit 1, channel field, event flags.
// - Filter word has one enable per event, at the matching entry flag position; MRF (bit 10) has no entry flag.
// - Filtered-out event raises no interrupt and writes no queue entry.
// - Write pointer is the next empty slot; start pointer is the first entry.
// - Entry body written first, then valid bit set, then pointer advanced.
// - At the entry whose wrap bit is set, pointer reloads from start pointer.
// - After an entry write, serial event flags are set by exception type.
// - Transmit attribute bit 3 selects little (0) or big (1) endian.
// - Transmit attribute bits 5 to 7 give the bus space code for DMA.
// - Entry fields and filter bits read as zero after reset.
`ifndef MCEQ_PARAMS_SVH
`define MCEQ_PARAMS_SVH

// Register byte offsets
`define MCEQ_OFS_FILTER 8'h00
`define MCEQ_OFS_TXATTR 8'h04
`define MCEQ_OFS_START 8'h08
`define MCEQ_OFS_WPTR 8'h0C
`define MCEQ_OFS_SEF 8'h10
`define MCEQ_OFS_SEF_MASK 8'h14

// Queue entry layout
`define MCEQ_E_VALID 0
`define MCEQ_E_WRAP 1
`define MCEQ_E_RSVD 4
`define MCEQ_E_CHAN_LO 5
`define MCEQ_E_CHAN_HI 10
`define MCEQ_ENTRY_FLAGS 16'hF80C
`define MCEQ_FILTER_DEFINED 16'hFC0C
`define MCEQ_ENTRY_STEP 32'h0000_0002

// Event positions in filter word and entry; MRF (bit 10) is in the filter word only
`define MCEQ_EV_MRF 10
`define MCEQ_EV_UN 11
`define MCEQ_EV_RXF 12
`define MCEQ_EV_TXB 14
`define MCEQ_EV_RXB 15

// Transmit attribute fields; bit 2 reads as one, bits 0, 1 and 4 as zero
`define MCEQ_TA_ENDIAN 3
`define MCEQ_TA_SPACE_LO 5
`define MCEQ_TA_SPACE_HI 7
`define MCEQ_TA_WMASK 8'hE8
`define MCEQ_TA_FIXED 8'h04

// Serial event flags layout
`define MCEQ_SEF_ENTRY 0
`define MCEQ_SEF_OVF 1
`define MCEQ_SEF_RX 2
`define MCEQ_SEF_TX 3
`define MCEQ_SEF_W 4

`define MCEQ_RST16 16'h0000
`define MCEQ_RST32 32'h0000_0000

`endif

// File: mceq_pkg.sv
// Types shared by the multichannel event queue
package mceq_pkg;
  typedef struct packed {
    logic [5:0] chan;
    logic [15:0] flags;
  } mceq_evt_t;

  typedef enum logic [2:0] {
    MCEQ_IDLE,
    MCEQ_READ,
    MCEQ_BODY,
    MCEQ_VALID,
    MCEQ_ADV
  } mceq_state_t;
endpackage

// File: mceq_top.sv
// Multichannel event queue: filter, circular entry writer, event flags, Wishbone slave
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "mceq_params.svh"

module mceq_top #(
  parameter int AW = 32
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  input wire logic EVT_VALID,
  input wire mceq_pkg::mceq_evt_t EVT_IN,
  output logic EVT_READY,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [AW-1:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic TX_BIG_ENDIAN,
  output logic [2:0] TX_BUS_SPACE,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] filter_r;
  logic [7:0] txattr_r;
  logic [AW-1:0] start_r;
  logic [AW-1:0] wptr_r;
  logic [`MCEQ_SEF_W-1:0] sef_r;
  logic [`MCEQ_SEF_W-1:0] sef_mask_r;
  logic [`MCEQ_SEF_W-1:0] sef_set;
  logic [5:0] chan_r;
  logic [15:0] flags_r;
  logic wrap_r;
  mceq_pkg::mceq_state_t state_r;
  logic wb_hit;
  logic wb_wr;
  logic [15:0] survive;
  logic take;
  logic [31:0] wb_cur;
  logic [31:0] wb_new;

  function automatic logic [15:0] make_entry(input logic [5:0] chan,
                                             input logic [15:0] flags,
                                             input logic wrap, input logic valid);
    logic [15:0] e;
    e = flags & `MCEQ_ENTRY_FLAGS;
    e[`MCEQ_E_CHAN_HI:`MCEQ_E_CHAN_LO] = chan;
    e[`MCEQ_E_WRAP] = wrap;
    e[`MCEQ_E_VALID] = valid;
    return e;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Undefined filter bits are masked here too, so a careless write cannot create events
  assign survive = EVT_IN.flags & filter_r & `MCEQ_FILTER_DEFINED;
  assign take = EVT_VALID && EVT_READY;
  assign wb_hit = WB_CYC && WB_STB && !WB_ACK;
  assign wb_wr = wb_hit && WB_WE;

  // Current value of the addressed register, so unselected byte lanes keep their contents
  always_comb begin
    wb_cur = `MCEQ_RST32;
    unique case (WB_ADR)
      `MCEQ_OFS_FILTER: wb_cur = 32'(filter_r);
      `MCEQ_OFS_TXATTR: wb_cur = 32'(txattr_r);
      `MCEQ_OFS_START: wb_cur = 32'(start_r);
      `MCEQ_OFS_WPTR: wb_cur = 32'(wptr_r);
      `MCEQ_OFS_SEF_MASK: wb_cur = 32'(sef_mask_r);
      default: wb_cur = `MCEQ_RST32;
    endcase
  end

  assign wb_new = merge(wb_cur, WB_DAT_I, WB_SEL);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one-cycle registered answer, unmapped reads return zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= `MCEQ_RST32;
    end else begin
      WB_ACK <= wb_hit;
      if (wb_hit && !WB_WE) begin
        unique case (WB_ADR)
          `MCEQ_OFS_FILTER: WB_DAT_O <= {16'h0000, filter_r};
          `MCEQ_OFS_TXATTR: WB_DAT_O <= {24'h000000, txattr_r | `MCEQ_TA_FIXED};
          `MCEQ_OFS_START: WB_DAT_O <= 32'(start_r);
          `MCEQ_OFS_WPTR: WB_DAT_O <= 32'(wptr_r);
          `MCEQ_OFS_SEF: WB_DAT_O <= 32'(sef_r);
          `MCEQ_OFS_SEF_MASK: WB_DAT_O <= 32'(sef_mask_r);
          default: WB_DAT_O <= `MCEQ_RST32;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      filter_r <= `MCEQ_RST16;
      txattr_r <= 8'h00;
      start_r <= '0;
      sef_mask_r <= '0;
    end else if (wb_wr) begin
      unique case (WB_ADR)
        `MCEQ_OFS_FILTER: filter_r <= wb_new[15:0];
        `MCEQ_OFS_TXATTR: txattr_r <= wb_new[7:0] & `MCEQ_TA_WMASK;
        `MCEQ_OFS_START: start_r <= AW'(wb_new);
        `MCEQ_OFS_SEF_MASK: sef_mask_r <= wb_new[`MCEQ_SEF_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue engine: read the slot, write body, then set valid, then move on
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= mceq_pkg::MCEQ_IDLE;
      EVT_READY <= 1'b0;
      chan_r <= 6'h00;
      flags_r <= `MCEQ_RST16;
      wrap_r <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= `MCEQ_RST16;
    end else begin
      unique case (state_r)
        mceq_pkg::MCEQ_IDLE: begin
          EVT_READY <= 1'b1;
          if (take) begin
            EVT_READY <= 1'b0;
            if (survive != `MCEQ_RST16) begin
              chan_r <= EVT_IN.chan;
              flags_r <= survive;
              MEM_REQ <= 1'b1;
              MEM_WE <= 1'b0;
              MEM_ADDR <= wptr_r;
              state_r <= mceq_pkg::MCEQ_READ;
            end
          end
        end
        mceq_pkg::MCEQ_READ: begin
          if (MEM_REQ && MEM_ACK) begin
            MEM_REQ <= 1'b0;
            wrap_r <= MEM_RDATA[`MCEQ_E_WRAP];
            if (MEM_RDATA[`MCEQ_E_VALID]) begin
              state_r <= mceq_pkg::MCEQ_IDLE;
            end else begin
              state_r <= mceq_pkg::MCEQ_BODY;
            end
          end
        end
        mceq_pkg::MCEQ_BODY: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b1;
            MEM_WDATA <= make_entry(chan_r, flags_r, wrap_r, 1'b0);
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            state_r <= mceq_pkg::MCEQ_VALID;
          end
        end
        mceq_pkg::MCEQ_VALID: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WDATA <= make_entry(chan_r, flags_r, wrap_r, 1'b1);
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            state_r <= mceq_pkg::MCEQ_ADV;
          end
        end
        mceq_pkg::MCEQ_ADV: begin
          state_r <= mceq_pkg::MCEQ_IDLE;
        end
      endcase
    end
  end

  // Host may rewrite the pointer at any time; doing so mid-entry is its own hazard
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wptr_r <= '0;
    end else if (wb_wr && WB_ADR == `MCEQ_OFS_WPTR) begin
      wptr_r <= AW'(wb_new);
    end else if (state_r == mceq_pkg::MCEQ_ADV) begin
      if (wrap_r) begin
        wptr_r <= start_r;
      end else begin
        wptr_r <= wptr_r + AW'(`MCEQ_ENTRY_STEP);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial event flags: read clears, a set in the same cycle wins
  always_comb begin
    sef_set = '0;
    if (state_r == mceq_pkg::MCEQ_ADV) begin
      sef_set[`MCEQ_SEF_ENTRY] = 1'b1;
      sef_set[`MCEQ_SEF_RX] = flags_r[`MCEQ_EV_RXB] | flags_r[`MCEQ_EV_RXF]
                              | flags_r[`MCEQ_EV_MRF];
      sef_set[`MCEQ_SEF_TX] = flags_r[`MCEQ_EV_TXB] | flags_r[`MCEQ_EV_UN];
    end
    if (state_r == mceq_pkg::MCEQ_READ && MEM_REQ && MEM_ACK && MEM_RDATA[`MCEQ_E_VALID]) begin
      sef_set[`MCEQ_SEF_OVF] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sef_r <= '0;
    end else if (wb_hit && !WB_WE && WB_ADR == `MCEQ_OFS_SEF) begin
      sef_r <= sef_set;
    end else begin
      sef_r <= sef_r | sef_set;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
      TX_BIG_ENDIAN <= 1'b0;
      TX_BUS_SPACE <= 3'h0;
    end else begin
      IRQ <= |(sef_r & sef_mask_r);
      TX_BIG_ENDIAN <= txattr_r[`MCEQ_TA_ENDIAN];
      TX_BUS_SPACE <= txattr_r[`MCEQ_TA_SPACE_HI:`MCEQ_TA_SPACE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  wb_ack_single_a: assert property (WB_ACK |=> !WB_ACK)
    else $error("bus ack held more than one cycle");
  wb_ack_answer_a: assert property (wb_hit |=> WB_ACK)
    else $error("bus request not answered in one cycle");
  filter_drop_a: assert property (
    (take && survive == `MCEQ_RST16) |=> state_r == mceq_pkg::MCEQ_IDLE && !MEM_REQ)
    else $error("filtered event started a queue access");
  body_before_valid_a: assert property (
    (state_r == mceq_pkg::MCEQ_BODY && MEM_REQ) |-> MEM_WE && !MEM_WDATA[`MCEQ_E_VALID])
    else $error("entry body written with valid bit set");
  valid_write_a: assert property (
    (state_r == mceq_pkg::MCEQ_BODY && MEM_REQ && MEM_ACK)
      |=> ##1 MEM_REQ && MEM_WE && MEM_WDATA[`MCEQ_E_VALID] && MEM_ADDR == $past(MEM_ADDR, 2))
    else $error("valid bit not written to the same slot after the body");
  entry_layout_a: assert property (
    (MEM_REQ && MEM_WE) |-> MEM_WDATA[`MCEQ_E_CHAN_HI:`MCEQ_E_CHAN_LO] == chan_r
      && (MEM_WDATA & `MCEQ_ENTRY_FLAGS) == (flags_r & `MCEQ_ENTRY_FLAGS)
      && !MEM_WDATA[`MCEQ_E_RSVD])
    else $error("entry channel field or flags wrong");
  wrap_reload_a: assert property (
    (state_r == mceq_pkg::MCEQ_ADV && wrap_r && !wb_wr) |=> wptr_r == $past(start_r))
    else $error("pointer not reloaded at wrap entry");
  advance_a: assert property (
    (state_r == mceq_pkg::MCEQ_ADV && !wrap_r && !wb_wr)
      |=> wptr_r == $past(wptr_r) + AW'(`MCEQ_ENTRY_STEP))
    else $error("pointer not advanced by one entry");
  flag_after_entry_a: assert property (
    state_r == mceq_pkg::MCEQ_ADV |=> sef_r[`MCEQ_SEF_ENTRY])
    else $error("entry flag not set after queue write");
  overflow_a: assert property (
    (state_r == mceq_pkg::MCEQ_READ && MEM_REQ && MEM_ACK && MEM_RDATA[`MCEQ_E_VALID])
      |=> sef_r[`MCEQ_SEF_OVF] && state_r == mceq_pkg::MCEQ_IDLE && !MEM_WE)
    else $error("occupied slot not reported as overflow");
  reset_zero_a: assert property (disable iff (1'b0)
    RESET |=> filter_r == `MCEQ_RST16 && flags_r == `MCEQ_RST16)
    else $error("filter or entry fields not zero after reset");
  endian_a: assert property (
    TX_BIG_ENDIAN == $past(txattr_r[`MCEQ_TA_ENDIAN]))
    else $error("endian output does not follow attribute");
  space_a: assert property (
    TX_BUS_SPACE == $past(txattr_r[`MCEQ_TA_SPACE_HI:`MCEQ_TA_SPACE_LO]))
    else $error("bus space output does not follow attribute");
  irq_a: assert property (IRQ == $past(|(sef_r & sef_mask_r)))
    else $error("interrupt output does not follow masked flags");

  entry_done_c: cover property (state_r == mceq_pkg::MCEQ_ADV && !wrap_r);
  wrap_done_c: cover property (state_r == mceq_pkg::MCEQ_ADV && wrap_r);
  overflow_c: cover property (sef_set[`MCEQ_SEF_OVF]);
  irq_c: cover property (IRQ);
  filter_drop_c: cover property (take && survive == `MCEQ_RST16);

endmodule // mceq_top

// File: mceq_mem_model.sv
// Memory model standing in for the shared queue table, with a settable answer latency
`timescale 1ns/100ps

module mceq_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] lat,
  output logic [15:0] rdata,
  output logic ack,
  output int wr_cnt
);
  logic [15:0] ram [0:255];
  int cnt;
  initial begin
    for (int i = 0; i < 256; i++) ram[i] = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data is only good in the ack cycle; otherwise it toggles so stale
  // values cannot pass for an answer
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt <= 0;
      wr_cnt <= 0;
      rdata <= 16'h0000;
    end else if (req && !ack) begin
      if (cnt >= lat) begin
        ack <= 1'b1;
        cnt <= 0;
        rdata <= ram[addr[8:1]];
        if (we) begin
          ram[addr[8:1]] <= wdata;
          wr_cnt <= wr_cnt + 1;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // mceq_mem_model

// File: multichannel_event_queue_test.sv
// Self-checking bench for the multichannel event queue
`timescale 1ns/100ps

module multichannel_event_queue_test;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ev_v = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, lat = 4'h0;
  logic [31:0] dati = 32'h0000_0000, dato, q, m_addr;
  logic ack, ev_rdy, m_req, m_we, m_ack, big, irq;
  logic [2:0] space;
  logic [15:0] m_wd, m_rd;
  mceq_pkg::mceq_evt_t ev = '0;
  int err_total = 0, cmp_count = 0, wc, wr_cnt;

  mceq_top dut (.SYS_CLK(clk), .RESET(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK(ack),
    .EVT_VALID(ev_v), .EVT_IN(ev), .EVT_READY(ev_rdy), .MEM_REQ(m_req), .MEM_WE(m_we),
    .MEM_ADDR(m_addr), .MEM_WDATA(m_wd), .MEM_RDATA(m_rd), .MEM_ACK(m_ack),
    .TX_BIG_ENDIAN(big), .TX_BUS_SPACE(space), .IRQ(irq));
  mceq_mem_model mem (.clk(clk), .rst(rst), .req(m_req), .we(m_we), .addr(m_addr),
    .wdata(m_wd), .lat(lat), .rdata(m_rd), .ack(m_ack), .wr_cnt(wr_cnt));

  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dati <= d; sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dato;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk(1'b0, 1'b1);
  endtask

  task automatic post(input logic [5:0] ch, input logic [15:0] fl);
    int n = 0;
    @(posedge clk);
    ev_v <= 1'b1;
    ev <= mceq_pkg::mceq_evt_t'({ch, fl});
    do @(posedge clk); while (ev_rdy !== 1'b1);
    ev_v <= 1'b0;
    repeat (2) @(posedge clk);
    while (ev_rdy !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) chk(1'b0, 1'b1);
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wb(1'b0, 8'h00, 0); chk(q, 32'h0000_0000);
    wb(1'b0, 8'h04, 0); chk(q, 32'h0000_0004);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 0); chk(q, 32'h0000_0000);
    $display("reset test done");
  endtask

  task automatic t_attr();
    wb(1'b1, 8'h04, 32'h0000_00FF);
    @(posedge clk);
    chk(big, 1'b1);
    chk(space, 3'h7);
    wb(1'b0, 8'h04, 0); chk(q, 32'h0000_00EC);
    wb(1'b1, 8'h04, 32'h0000_0020);
    @(posedge clk);
    chk(big, 1'b0);
    chk(space, 3'h1);
    $display("attribute test done");
  endtask

  task automatic t_filtered();
    wb(1'b1, 8'h08, 32'h0000_0100);
    wb(1'b1, 8'h0C, 32'h0000_0100);
    post(6'h01, 16'h4000); chk(wr_cnt, 0);
    wb(1'b0, 8'h0C, 0); chk(q, 32'h0000_0100);
    wb(1'b0, 8'h10, 0); chk(q, 32'h0000_0000);
    $display("filtered test done");
  endtask

  // Slow memory, slot carries the wrap mark set by software
  task automatic t_wrap();
    mem.ram[8'h81] = 16'h0002;
    wb(1'b1, 8'h00, 32'h0000_FC0C);
    wb(1'b1, 8'h0C, 32'h0000_0102);
    wb(1'b1, 8'h14, 32'h0000_001F);
    lat <= 4'h3;
    post(6'h05, 16'h4004); chk(mem.ram[8'h81], 16'h40A7);
    chk(wr_cnt, 2);
    chk(irq, 1'b1);
    wb(1'b0, 8'h0C, 0); chk(q, 32'h0000_0100);
    wb(1'b0, 8'h10, 0); chk(q, 32'h0000_0009);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("wrap test done");
  endtask

  task automatic t_linear();
    lat <= 4'h0;
    post(6'h03, 16'h0400); chk(mem.ram[8'h80], 16'h0061);
    wb(1'b0, 8'h0C, 0); chk(q, 32'h0000_0102);
    wb(1'b0, 8'h10, 0); chk(q, 32'h0000_0005);
    $display("linear test done");
  endtask

  // Slot still valid: dropped with overflow flag, masked so no interrupt
  task automatic t_overflow();
    wb(1'b1, 8'h0C, 32'h0000_0100);
    wb(1'b1, 8'h14, 32'h0000_0001);
    wc = wr_cnt;
    post(6'h07, 16'h8000); chk(wr_cnt, wc);
    chk(mem.ram[8'h80], 16'h0061);
    chk(irq, 1'b0);
    wb(1'b0, 8'h10, 0); chk(q, 32'h0000_0002);
    wb(1'b0, 8'h0C, 0); chk(q, 32'h0000_0100);
    $display("overflow test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_attr();
    t_filtered();
    t_wrap();
    t_linear();
    t_overflow();
    summarize();
  end

  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule // multichannel_event_queue_test
